// ===== verilog/dac_pkg.sv
// Purpose: Shared constants, register map and carriers for the accumulator datapath
// Assumes: 40-bit accumulators, 16-bit data words, 32-bit APB data
// Notes:   Register offsets are byte addresses, one aligned word each
package dac_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ACC_W   = 40;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned SHAMT_W = 6;
  localparam int unsigned ADDR_W  = 16;

  // ==========================================================================
  // Register map (byte offsets)
  localparam logic [7:0] REG_CORE_CTRL = 8'h00;
  localparam logic [7:0] REG_TRAP_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_ACCA_LO   = 8'h0C;
  localparam logic [7:0] REG_ACCA_HI   = 8'h10;
  localparam logic [7:0] REG_ACCB_LO   = 8'h14;
  localparam logic [7:0] REG_ACCB_HI   = 8'h18;
  localparam logic [7:0] REG_WB_PTR    = 8'h1C;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CC_CLIP_EN_A  = 7;
  localparam int unsigned CC_CLIP_EN_B  = 6;
  localparam int unsigned CC_MEM_CLIP   = 5;
  localparam int unsigned CC_WIDTH_SEL  = 4;
  localparam int unsigned CC_ROUND_KIND = 1;
  localparam int unsigned TC_GUARD_A    = 0;
  localparam int unsigned TC_GUARD_B    = 1;
  localparam int unsigned TC_CATAST     = 2;
  localparam int unsigned ST_GUARD_A    = 0;
  localparam int unsigned ST_GUARD_B    = 1;
  localparam int unsigned ST_CLIP_A     = 2;
  localparam int unsigned ST_CLIP_B     = 3;
  localparam int unsigned ST_EITHER_GRD = 4;
  localparam int unsigned ST_EITHER_CLP = 5;
  localparam logic [15:0] CORE_CTRL_RESET = 16'h0000;
  localparam logic [2:0]  TRAP_CTRL_RESET = 3'h0;
  localparam logic [15:0] WB_PTR_RESET    = 16'h0000;

  // ==========================================================================
  // Saturation limits and arithmetic constants
  localparam logic [39:0] SAT40_POS   = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT40_NEG   = 40'h8000000000;
  localparam logic [39:0] SAT32_POS   = 40'h007FFFFFFF;
  localparam logic [39:0] SAT32_NEG   = 40'hFF80000000;
  localparam logic [15:0] MEM_POS     = 16'h7FFF;
  localparam logic [15:0] MEM_NEG     = 16'h8000;
  localparam logic [8:0]  MEM_TOP_POS = 9'h000;
  localparam logic [8:0]  MEM_TOP_NEG = 9'h1FF;
  localparam logic [15:0] PTR_STEP    = 16'h0002;
  localparam logic [5:0]  SHIFT_MAX   = 6'h10;

  // ==========================================================================
  // Operations issued by instruction decode
  typedef enum logic [3:0] {
    OP_NOP           = 4'h0,
    OP_SHIFT_ADD     = 4'h1,
    OP_SHIFT_SUB     = 4'h2,
    OP_SHIFT_LOAD    = 4'h3,
    OP_MULT_ACCUM    = 4'h4,
    OP_MULT_SUB      = 4'h5,
    OP_MULT_LOAD     = 4'h6,
    OP_MULT_NEG_LOAD = 4'h7,
    OP_SQ_DIST       = 4'h8,
    OP_SQ_DIST_ACCUM = 4'h9,
    OP_ACC_ADD       = 4'hA,
    OP_ACC_SUB       = 4'hB,
    OP_ACC_NEG       = 4'hC,
    OP_STORE_TRUNC   = 4'hD,
    OP_STORE_ROUND   = 4'hE,
    OP_MCU_SHIFT     = 4'hF
  } dac_op_type;

  typedef struct packed {
    dac_op_type          op;
    logic                targetB;
    logic                shiftFromX;
    logic                shiftSrcB;
    logic                shiftLogical;
    logic [SHAMT_W-1:0]  shiftAmount;
    logic [ACC_W-1:0]    product;
    logic [WORD_W-1:0]   xData;
    logic [ADDR_W-1:0]   storeAddr;
    logic                wbEnable;
    logic                wbIndirect;
  } dac_cmd_type;

  typedef struct packed {
    logic               valid;
    logic [ADDR_W-1:0]  addr;
    logic [WORD_W-1:0]  data;
  } dac_mem_write_type;

endpackage

// ===== verilog/dac_accum_datapath.sv
// Purpose: Accumulator datapath: adder/subtracter, saturation, round, write clip, shifter
// Assumes: Decode issues at most one command per cycle on the core clock
// Notes:   APB answers in the first access cycle
//
// Overview of operation
// (RL1) 40-bit sign-extended adder; A or B is source and destination; shifter scales operand.
// (RL2) Add: carry in active high, operand true; subtract: borrow low, operand inverted.
// (RL3) Guard flag set when result bits 39..32 are not all identical.
// (RL4) Guard flags rewritten on every adder pass, reflecting only the latest one.
// (RL5) Guard flag set with its trap enable raises an arithmetic warning trap.
// (RL6) Clip flags set by adder passes only; cleared only by a software write.
// (RL7) Status shows OR of both guard flags and OR of both clip flags.
// (RL8) Saturation uses adder result, overflow, per-accumulator enables and width select.
// (RL9) 40-bit mode: bit 39 overflow loads 9.31 extreme and sets clip flag.
// (RL10) 32-bit mode: bit 31 overflow loads 1.31 extreme; guard flags never set.
// (RL11) Saturation off: wraps freely; bit 39 overflow sets clip flag, may trap.
// (RL12) Multiply-accumulate ops may write rounded bits 31..16 of non-target accumulator.
// (RL13) Write-back direct into pointer register, or indirect to its address then +2.
// (RL14) Conventional rounding increments high word when low word is 0x8000 or above.
// (RL15) Convergent rounding: low word exactly 0x8000 increments only if bit 16 set.
// (RL16) Combinational round, mode from round kind bit; no rounding truncates low word.
// (RL17) Store truncates, rounded store rounds, write-back always rounds; all write-clipped.
// (RL18) Write clip: above 0x007FFF gives 0x7FFF, below 0xFF8000 gives 0x8000.
// (RL19) Write clip sign from bit 39; clip disabled passes value unmodified.
// (RL20) Shifter: arithmetic/logical right or left up to 16 bits, accumulator or X source.
// (RL21) Signed shift amount: positive right, negative left, zero unchanged.
// (RL22) 40-bit shifter; X data at bits 31..16 for right, low bits for left.
// (RL23) Width select one gives 9.31 saturation, zero gives 1.31 saturation.
// (RL24) Round kind one gives conventional rounding, zero gives convergent rounding.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dac_accum_datapath
  import dac_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Command from instruction decode
  input  wire logic               cmdValid,
  input  wire dac_cmd_type        cmd,
  // Results towards data space and core
  output dac_mem_write_type       memWrite,
  output logic      [WORD_W-1:0]  writebackPointer,
  output logic      [WORD_W-1:0]  mcuShiftResult,
  output logic      [ACC_W-1:0]   accumA,
  output logic      [ACC_W-1:0]   accumB,
  output logic                    arithWarnTrap
);

  // ==========================================================================
  // State
  logic [ACC_W-1:0]   accA_q;
  logic [ACC_W-1:0]   accB_q;
  logic               guardA_q;
  logic               guardB_q;
  logic               clipA_q;
  logic               clipB_q;
  logic [15:0]        coreCtrl_q;
  logic [2:0]         trapCtrl_q;
  logic [WORD_W-1:0]  wbPtr_q;
  dac_mem_write_type  memWrite_q;
  logic [WORD_W-1:0]  mcuShift_q;
  logic               trap_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;

  // ==========================================================================
  // Control decode
  logic clipEnA;
  logic clipEnB;
  logic memClipEn;
  logic widthSuper;
  logic roundKind;
  assign clipEnA    = coreCtrl_q[CC_CLIP_EN_A];
  assign clipEnB    = coreCtrl_q[CC_CLIP_EN_B];
  assign memClipEn  = coreCtrl_q[CC_MEM_CLIP];
  assign widthSuper = coreCtrl_q[CC_WIDTH_SEL];
  assign roundKind  = coreCtrl_q[CC_ROUND_KIND];

  logic apbWrite;
  logic apbSetup;
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready_q && pwrite;

  // ==========================================================================
  // Barrel shifter
  logic [ACC_W-1:0]   shiftSrc;
  logic [ACC_W-1:0]   shifted;
  logic [SHAMT_W-1:0] shiftMag;
  logic               shiftLeft;
  always_comb begin
    shiftLeft = cmd.shiftAmount[SHAMT_W-1];                                   // (RL21)
    shiftMag  = shiftLeft ? SHAMT_W'(-cmd.shiftAmount) : cmd.shiftAmount;
    if (shiftMag > SHIFT_MAX) begin
      shiftMag = SHIFT_MAX;                                                   // (RL20)
    end
    if (cmd.shiftFromX) begin
      if (shiftLeft) begin
        shiftSrc = {{(ACC_W-WORD_W){cmd.xData[WORD_W-1]}}, cmd.xData};        // (RL22)
      end else if (cmd.shiftLogical) begin
        shiftSrc = {8'h00, cmd.xData, 16'h0000};                              // (RL22)
      end else begin
        shiftSrc = {{8{cmd.xData[WORD_W-1]}}, cmd.xData, 16'h0000};           // (RL22)
      end
    end else begin
      shiftSrc = cmd.shiftSrcB ? accB_q : accA_q;                             // (RL20)
    end
    if (shiftLeft) begin
      shifted = shiftSrc << shiftMag;                                         // (RL21)
    end else if (cmd.shiftLogical) begin
      shifted = shiftSrc >> shiftMag;                                         // (RL20)
    end else begin
      shifted = ACC_W'($signed(shiftSrc) >>> shiftMag);                       // (RL20)
    end
  end

  // ==========================================================================
  // Adder/subtracter operand selection
  logic [ACC_W-1:0] accT;
  logic [ACC_W-1:0] accN;
  logic [ACC_W-1:0] opA;
  logic [ACC_W-1:0] opB;
  logic             doSub;
  logic             useAdder;
  logic             wbAllowed;
  always_comb begin
    accT      = cmd.targetB ? accB_q : accA_q;                                // (RL1)
    accN      = cmd.targetB ? accA_q : accB_q;
    opA       = accT;
    opB       = cmd.product;
    doSub     = 1'b0;
    useAdder  = 1'b1;
    wbAllowed = 1'b0;
    case (cmd.op)
      OP_SHIFT_ADD:     opB = shifted;                                        // (RL1)
      OP_SHIFT_SUB: begin
        opB   = shifted;
        doSub = 1'b1;
      end
      OP_SHIFT_LOAD: begin
        opA = '0;
        opB = shifted;                                                        // (RL1)
      end
      OP_MULT_ACCUM:    wbAllowed = 1'b1;                                     // (RL12)
      OP_MULT_SUB: begin
        doSub     = 1'b1;
        wbAllowed = 1'b1;                                                     // (RL12)
      end
      OP_MULT_LOAD:     opA = '0;
      OP_MULT_NEG_LOAD: begin
        opA   = '0;
        doSub = 1'b1;
      end
      OP_SQ_DIST:       opA = '0;
      OP_SQ_DIST_ACCUM: opA = accT;
      OP_ACC_ADD:       opB = accN;
      OP_ACC_SUB: begin
        opB   = accN;
        doSub = 1'b1;
      end
      OP_ACC_NEG: begin
        opA   = '0;
        opB   = accT;
        doSub = 1'b1;
      end
      default:          useAdder = 1'b0;
    endcase
  end

  // ==========================================================================
  // Adder, overflow detection and saturation
  logic [ACC_W:0]   sumExt;
  logic [ACC_W-1:0] rawSum;
  logic [ACC_W-1:0] newAcc;
  logic             ovf39;
  logic             ovf31;
  logic             guardRaw;
  logic             newGuard;
  logic             clipEvent;
  logic             catastEvent;
  logic             clipEn;
  always_comb begin
    // Inverted operand plus carry one is the subtract without a separate negate
    sumExt = {opA[ACC_W-1], opA}
           + (doSub ? ~{opB[ACC_W-1], opB} : {opB[ACC_W-1], opB})           // (RL2)
           + {{ACC_W{1'b0}}, doSub};                                          // (RL2)
    rawSum   = sumExt[ACC_W-1:0];
    ovf39    = sumExt[ACC_W] ^ sumExt[ACC_W-1];
    guardRaw = !((&rawSum[39:32]) || !(|rawSum[39:32]));                      // (RL3)
    ovf31    = ovf39 || !((&rawSum[39:31]) || !(|rawSum[39:31]));
    clipEn   = cmd.targetB ? clipEnB : clipEnA;                               // (RL8)
    newAcc      = rawSum;
    newGuard    = guardRaw;
    clipEvent   = 1'b0;
    catastEvent = 1'b0;
    if (clipEn && widthSuper) begin                                           // (RL23)
      if (ovf39) begin
        newAcc    = sumExt[ACC_W] ? SAT40_NEG : SAT40_POS;                    // (RL9)
        clipEvent = 1'b1;                                                     // (RL9)
      end
    end else if (clipEn) begin
      newGuard = 1'b0;                                                        // (RL10)
      if (ovf31) begin
        newAcc    = sumExt[ACC_W] ? SAT32_NEG : SAT32_POS;                    // (RL10)
        clipEvent = 1'b1;                                                     // (RL10)
      end
    end else begin
      clipEvent   = ovf39;                                                    // (RL11)
      catastEvent = ovf39;                                                    // (RL11)
    end
  end

  // ==========================================================================
  // Round and data space write clip
  function automatic logic [WORD_W-1:0] round_clip(
    input logic [ACC_W-1:0] acc,
    input logic             doRound,
    input logic             conventional,
    input logic             clipOn
  );
    logic        inc;
    logic [23:0] hiExt;
    logic [WORD_W-1:0] result;
    inc = 1'b0;
    if (doRound) begin
      // Tie case checks bit 16 so convergent rounding stays unbiased
      inc = acc[15] && (conventional || (|acc[14:0]) || acc[16]);             // (RL14) (RL15) (RL24)
    end
    hiExt  = acc[39:16] + {23'h0, inc};                                       // (RL16)
    result = hiExt[WORD_W-1:0];                                               // (RL16)
    if (clipOn) begin
      if (!acc[ACC_W-1] && (hiExt[23:15] != MEM_TOP_POS)) begin               // (RL19)
        result = MEM_POS;                                                     // (RL18)
      end else if (acc[ACC_W-1] && (hiExt[23:15] != MEM_TOP_NEG)) begin       // (RL19)
        result = MEM_NEG;                                                     // (RL18)
      end
    end
    return result;
  endfunction

  logic [WORD_W-1:0] storeWord;
  logic [WORD_W-1:0] wbWord;
  logic              wbFires;
  logic              storeFires;
  always_comb begin
    storeWord  = round_clip(accT, cmd.op == OP_STORE_ROUND, roundKind, memClipEn); // (RL17)
    wbWord     = round_clip(accN, 1'b1, roundKind, memClipEn);                // (RL17)
    wbFires    = cmdValid && wbAllowed && cmd.wbEnable;                       // (RL12)
    storeFires = cmdValid && ((cmd.op == OP_STORE_TRUNC) || (cmd.op == OP_STORE_ROUND));
  end

  // ==========================================================================
  // Accumulators: a command wins over a software write in the same cycle
  logic accAUpdate;
  logic accBUpdate;
  assign accAUpdate = cmdValid && useAdder && !cmd.targetB;
  assign accBUpdate = cmdValid && useAdder && cmd.targetB;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      accA_q <= '0;
    end else if (accAUpdate) begin
      accA_q <= newAcc;                                                       // (RL1)
    end else if (apbWrite && paddr == REG_ACCA_LO) begin
      accA_q <= {accA_q[39:32], pwdata};
    end else if (apbWrite && paddr == REG_ACCA_HI) begin
      accA_q <= {pwdata[7:0], accA_q[31:0]};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      accB_q <= '0;
    end else if (accBUpdate) begin
      accB_q <= newAcc;                                                       // (RL1)
    end else if (apbWrite && paddr == REG_ACCB_LO) begin
      accB_q <= {accB_q[39:32], pwdata};
    end else if (apbWrite && paddr == REG_ACCB_HI) begin
      accB_q <= {pwdata[7:0], accB_q[31:0]};
    end
  end

  // ==========================================================================
  // Overflow and clip flags
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      guardA_q <= 1'b0;
      guardB_q <= 1'b0;
    end else begin
      if (accAUpdate) begin
        guardA_q <= newGuard;                                                 // (RL4)
      end
      if (accBUpdate) begin
        guardB_q <= newGuard;                                                 // (RL4)
      end
    end
  end

  // Write one to clear; a set in the same cycle wins
  logic clrClipA;
  logic clrClipB;
  assign clrClipA = apbWrite && (paddr == REG_STATUS) && pwdata[ST_CLIP_A];
  assign clrClipB = apbWrite && (paddr == REG_STATUS) && pwdata[ST_CLIP_B];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clipA_q <= 1'b0;
      clipB_q <= 1'b0;
    end else begin
      clipA_q <= (clipA_q && !clrClipA) || (accAUpdate && clipEvent);         // (RL6)
      clipB_q <= (clipB_q && !clrClipB) || (accBUpdate && clipEvent);         // (RL6)
    end
  end

  // One-cycle request per offending command
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= (accAUpdate && newGuard && trapCtrl_q[TC_GUARD_A])            // (RL5)
             || (accBUpdate && newGuard && trapCtrl_q[TC_GUARD_B])            // (RL5)
             || (cmdValid && useAdder && catastEvent && trapCtrl_q[TC_CATAST]); // (RL11)
    end
  end

  // ==========================================================================
  // Write-back pointer and data space writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wbPtr_q <= WB_PTR_RESET;
    end else if (wbFires && cmd.wbIndirect) begin
      wbPtr_q <= wbPtr_q + PTR_STEP;                                          // (RL13)
    end else if (wbFires) begin
      wbPtr_q <= wbWord;                                                      // (RL13)
    end else if (apbWrite && paddr == REG_WB_PTR) begin
      wbPtr_q <= pwdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      memWrite_q <= '0;
    end else if (wbFires && cmd.wbIndirect) begin
      memWrite_q.valid <= 1'b1;
      memWrite_q.addr  <= wbPtr_q;                                            // (RL13)
      memWrite_q.data  <= wbWord;                                             // (RL12)
    end else if (storeFires) begin
      memWrite_q.valid <= 1'b1;
      memWrite_q.addr  <= cmd.storeAddr;
      memWrite_q.data  <= storeWord;                                          // (RL17)
    end else begin
      memWrite_q.valid <= 1'b0;
    end
  end

  // Right form takes bits 31..16, left form the low word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mcuShift_q <= '0;
    end else if (cmdValid && cmd.op == OP_MCU_SHIFT) begin
      mcuShift_q <= shiftLeft ? shifted[15:0] : shifted[31:16];               // (RL22)
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      coreCtrl_q <= CORE_CTRL_RESET;
      trapCtrl_q <= TRAP_CTRL_RESET;
    end else if (apbWrite && paddr == REG_CORE_CTRL) begin
      coreCtrl_q <= pwdata[15:0];
    end else if (apbWrite && paddr == REG_TRAP_CTRL) begin
      trapCtrl_q <= pwdata[2:0];
    end
  end

  // ==========================================================================
  // APB read path, answered in the cycle after setup
  logic [31:0] readMux;
  logic        mapped;
  always_comb begin
    readMux = '0;
    mapped  = 1'b1;
    case (paddr)
      REG_CORE_CTRL: readMux = {16'h0000, coreCtrl_q};
      REG_TRAP_CTRL: readMux = {29'h0, trapCtrl_q};
      REG_STATUS: begin
        readMux[ST_GUARD_A]    = guardA_q;
        readMux[ST_GUARD_B]    = guardB_q;
        readMux[ST_CLIP_A]     = clipA_q;
        readMux[ST_CLIP_B]     = clipB_q;
        readMux[ST_EITHER_GRD] = guardA_q || guardB_q;                        // (RL7)
        readMux[ST_EITHER_CLP] = clipA_q || clipB_q;                          // (RL7)
      end
      REG_ACCA_LO:   readMux = accA_q[31:0];
      REG_ACCA_HI:   readMux = {24'h000000, accA_q[39:32]};
      REG_ACCB_LO:   readMux = accB_q[31:0];
      REG_ACCB_HI:   readMux = {24'h000000, accB_q[39:32]};
      REG_WB_PTR:    readMux = {16'h0000, wbPtr_q};
      default:       mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apbSetup;
      pslverr_q <= apbSetup && !mapped;
      if (apbSetup) begin
        prdata_q <= pwrite ? 32'h00000000 : readMux;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign memWrite         = memWrite_q;
  assign writebackPointer = wbPtr_q;
  assign mcuShiftResult   = mcuShift_q;
  assign accumA           = accA_q;
  assign accumB           = accB_q;
  assign arithWarnTrap    = trap_q;

endmodule

`default_nettype wire

// ===== testbench/dac_accum_monitor.sv
// Purpose: Port assertions for the accumulator datapath
// Assumes: One clock, reset active high
// Notes:   Watches the command side, write-back and trap only
`timescale 1ns/1ps
`default_nettype none
module dac_accum_monitor
  import dac_pkg::*;
(
  // Watched ports
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              cmdValid,
  input wire dac_cmd_type       cmd,
  input wire dac_mem_write_type memWrite,
  input wire logic [WORD_W-1:0] writebackPointer,
  input wire logic              arithWarnTrap
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic mac = cmdValid && cmd.wbEnable && cmd.op inside {OP_MULT_ACCUM, OP_MULT_SUB};
  wire logic sto = cmdValid && cmd.op inside {OP_STORE_TRUNC, OP_STORE_ROUND};
  wire logic nwb = cmdValid && cmd.op inside {OP_MULT_LOAD, OP_MULT_NEG_LOAD, OP_SQ_DIST,
                                              OP_SQ_DIST_ACCUM};
  // ==========================================================================
  // Write-back, store and trap
  property p_ind; mac && cmd.wbIndirect |=> memWrite.valid &&
    memWrite.addr == $past(writebackPointer); endproperty
  a_ind: assert property (p_ind) else $error("indirect address");
  property p_inc; mac && cmd.wbIndirect |=>
    writebackPointer == $past(writebackPointer) + PTR_STEP; endproperty
  a_inc: assert property (p_inc) else $error("pointer step");
  property p_dir; mac && !cmd.wbIndirect |=> !memWrite.valid; endproperty
  a_dir: assert property (p_dir) else $error("direct wrote memory");
  property p_nwb; nwb |=> !memWrite.valid && $stable(writebackPointer); endproperty
  a_nwb: assert property (p_nwb) else $error("excluded op wrote");
  property p_src; memWrite.valid |-> $past(cmdValid) &&
    $past(cmd.op) inside {OP_MULT_ACCUM, OP_MULT_SUB, OP_STORE_TRUNC, OP_STORE_ROUND}; endproperty
  a_src: assert property (p_src) else $error("stray write");
  property p_sto; sto |=> memWrite.valid && memWrite.addr == $past(cmd.storeAddr); endproperty
  a_sto: assert property (p_sto) else $error("store address");
  property p_keep; sto |=> $stable(writebackPointer) ##1
    (!memWrite.valid || $past(cmdValid)); endproperty
  a_keep: assert property (p_keep) else $error("store side effect");
  property p_trap; arithWarnTrap |-> $past(cmdValid) && !$past(sto); endproperty
  a_trap: assert property (p_trap) else $error("stray trap");
endmodule
bind dac_accum_datapath dac_accum_monitor u_mon (.clock, .reset, .cmdValid, .cmd, .memWrite,
  .writebackPointer, .arithWarnTrap);
`default_nettype wire

// ===== testbench/dac_mem_model.sv
// Purpose: Data-space word store fed by the datapath write port
// Assumes: Word writes at even addresses below 0x0400
// Notes:   Unwritten words stay unknown so a missing write fails
`timescale 1ns/1ps
`default_nettype none
module dac_mem_model
  import dac_pkg::*;
(
  // Write port
  input wire logic              clock,
  input wire dac_mem_write_type memWrite
);
  logic [WORD_W-1:0] mem [512];
  always @(posedge clock) if (memWrite.valid === 1'b1) mem[memWrite.addr[9:1]] <= memWrite.data;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the accumulator datapath
// Assumes: APB answers after one access cycle
// Notes:   Expected words come from the bench round model
`timescale 1ns/1ps
`default_nettype none
module tb_top import dac_pkg::*; ;
  logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmdValid = 1'b0;
  logic pready, pslverr, arithWarnTrap, err, trap;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h1ABF;
  logic [15:0] writebackPointer, mcuShiftResult, e, lows [4] = '{16'h8000, 16'h7FFF, 16'h8001, 16'hFFFF};
  logic [39:0] accumA, accumB, v;
  dac_cmd_type cmd = '0;
  dac_mem_write_type memWrite;
  int fail_count = 0, total_checks = 0;
  always #2.5 clock = ~clock;
  dac_accum_datapath dut (.*);
  dac_mem_model mdl (.*);
  // ==========================================================================
  // Tasks
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic ck(input logic [39:0] g, input logic [39:0] x);
    total_checks++;
    if (g !== x) fail_count++;
    if (g !== x) $display("unexpected at %0t: %h not %h", $time, g, x);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic cg(input dac_op_type op, input logic b, input logic [39:0] p,
                    input logic [15:0] a, input logic ind);
    @(posedge clock);
    {cmdValid, cmd} <= {1'b1, op, b, 3'b100, 6'h00, p, 16'(rnd()), a, 1'b1, ind};
    @(posedge clock);
    cmdValid <= 1'b0;
    #1 trap = arithWarnTrap;
    @(posedge clock);
    #1;
  endtask
  task automatic st(input logic [31:0] c, input logic r, input logic [15:0] a);
    apb(1'b1, REG_CORE_CTRL, c);
    cg(OP_MULT_LOAD, 1'b1, v, 16'h0, 1'b1);
    cg(r ? OP_STORE_ROUND : OP_STORE_TRUNC, 1'b1, 40'h0, a, 1'b0);
    ck(40'(mdl.mem[a[9:1]]), 40'(e));
    ck(accumB, v);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000 fail_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, 8'hFC, 32'h0);
    ck(40'(err), 40'h1);
    for (int i = 0; i < 32; i++) begin
      v = {8'h00, 15'(rnd()), i[4], lows[i[3:2]]};
      e = v[31:16] + 16'(i[1] && (v[15:0] > 16'h8000 || (v[15:0] == 16'h8000 && (i[0] || v[16]))));
      st({30'h0, i[0], 1'b0}, i[1], 16'(i * 2));
    end
    {v, e} = {40'h0080000000, MEM_POS};
    st(32'h20, 1'b0, 16'h0100);
    {v, e} = {40'hFF7FFF0000, MEM_NEG};
    st(32'h20, 1'b0, 16'h0102);
    {v, e} = {40'h0012348000, 16'h1234};
    st(32'h00, 1'b1, 16'h0104);
    apb(1'b1, REG_WB_PTR, 32'h200);
    cg(OP_MULT_ACCUM, 1'b0, 40'h1, 16'h0, 1'b1);
    ck(40'(mdl.mem[9'h100]), 40'h1234);
    apb(1'b1, REG_CORE_CTRL, 32'h90);
    cg(OP_MULT_LOAD, 1'b0, SAT40_POS, 16'h0, 1'b0);
    cg(OP_MULT_ACCUM, 1'b0, 40'h1, 16'h0, 1'b0);
    ck(accumA, SAT40_POS);
    cg(OP_MULT_ACCUM, 1'b0, 40'h0, 16'h0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    ck(40'(rd), 40'h35);
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_STATUS, 32'h0);
    ck(40'(rd), 40'h11);
    apb(1'b1, REG_TRAP_CTRL, 32'h1);
    cg(OP_MULT_ACCUM, 1'b0, 40'hFF80000000, 16'h0, 1'b0);
    ck(40'(trap), 40'h1);
    cg(OP_MCU_SHIFT, 1'b0, 40'h0, 16'h0, 1'b0);
    ck(40'(mcuShiftResult), 40'(cmd.xData));
    final_report();
  end
endmodule
`default_nettype wire
